// file: hdl/pplf_defines.svh
// Offsets, field positions, reset values and timing counts of the controller.
// Assumes a 40 MHz system clock and a 32-bit AXI4-Lite register bus.
`ifndef PPLF_DEFINES_SVH
`define PPLF_DEFINES_SVH
// ==========================================
// Register word indexes (byte address = 4 x index)
`define PPLF_R_CTRL  4'h0
`define PPLF_R_OLUV  4'h1
`define PPLF_R_OVREF 4'h2
`define PPLF_R_ACIN  4'h3
`define PPLF_R_BLANK 4'h4
`define PPLF_R_PFCT  4'h5
`define PPLF_R_PERD  4'h6
`define PPLF_R_SOFT  4'h7
`define PPLF_R_NOM   4'h8
`define PPLF_R_KFRQ  4'h9
`define PPLF_R_KVLT  4'hA
`define PPLF_R_STAT  4'hB
`define PPLF_R_STATE 4'hC
`define PPLF_R_LLCP  4'hD
`define PPLF_NCFG    11
// ==========================================
// Field positions
`define PPLF_LO 15:0
`define PPLF_HI 31:16
`define PPLF_B0 7:0
`define PPLF_B1 15:8
`define PPLF_B2 23:16
`define PPLF_B3 31:24
`define PPLF_ST_OL  0
`define PPLF_ST_OCP 1
`define PPLF_ST_OV1 2
`define PPLF_ST_OV2 3
`define PPLF_ST_UV  4
`define PPLF_ST_BI  5
`define PPLF_ST_BO  6
`define PPLF_ST_CCM 7
`define PPLF_ST_AR  8
`define PPLF_KSH    6
// ==========================================
// Reset values
`define PPLF_RST_CTRL  32'h0000_0001
`define PPLF_RST_OLUV  32'h0800_0100
`define PPLF_RST_OVREF 32'h0C00_0E00
`define PPLF_RST_ACIN  32'h0500_0600
`define PPLF_RST_BLANK 32'h4008_0810
`define PPLF_RST_PFCT  32'h0040_0100
`define PPLF_RST_PERD  32'h0100_0FA0
`define PPLF_RST_SOFT  32'h0004_0100
`define PPLF_RST_NOM   32'h0800_0190
`define PPLF_RST_KFRQ  32'h8050_3020
`define PPLF_RST_KVLT  32'h007F_6020
`define PPLF_OKAY      2'h0
`define PPLF_SLVERR    2'h2
// ==========================================
// Timing
`define PPLF_CLK_MHZ    40
`define PPLF_TICK_US    512
`define PPLF_MARGIN_NS  200
`define PPLF_TICK_CYC   (`PPLF_TICK_US * `PPLF_CLK_MHZ)
`define PPLF_MARGIN_CYC ((`PPLF_MARGIN_NS * `PPLF_CLK_MHZ + 999) / 1000)
`endif

// file: hdl/pplf_pkg.sv
// Types of the controller: system states and the state records.
// Assumes pplf_defines.svh is on the include path.
package pplf_pkg;
    `include "pplf_defines.svh"
    // ==========================================
    // System states, Gray coded along idle, start, run, restart.
    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_START = 2'b01,
        S_RUN   = 2'b11,
        S_RSTRT = 2'b10
    } pplf_sys_t;
    // ==========================================
    // Whole state of the top module.
    typedef struct packed {
        logic                         awRdy, wRdy, arRdy, awGot, wGot, awBad;
        logic                         bValid, rValid;
        logic [1:0]                   bResp, rResp;
        logic [3:0]                   awIdx, wStrb;
        logic [31:0]                  wData, rData;
        logic [`PPLF_NCFG-1:0][31:0]  cfg;
        logic [8:0]                   stat;
        pplf_sys_t                    sys;
        logic [15:0]                  tick, perCnt, ccmCnt, ssPer, ssStep, llcPer;
        logic                         tickP, pfcOn, pfcEn, llcEn, llcSoft;
        logic                         ovStop, uvStop, boStop;
        logic [7:0]                   brkCnt, uvCnt, boCnt, ovfCnt;
    } pplf_st_t;
    // Whole state of the period interpolator.
    typedef struct packed {
        logic [5:0]  cnt;
        logic [16:0] rem;
        logic [31:0] quo;
        logic [15:0] den, base, period, tMin;
    } pplf_vst_t;
endpackage

// file: hdl/pplf_vco_if.sv
// Link between the control core and its feedback period interpolator.
// Assumes one clock domain shared by both ends.
`timescale 1ns/1ps
interface pplf_vco_if;
    logic [15:0]      fb, tNom, vNom, period, tMin;
    logic [3:0][7:0]  kf;
    logic [2:0][7:0]  kv;
    modport ctl (output fb, tNom, vNom, kf, kv, input period, tMin);
    modport vco (input fb, tNom, vNom, kf, kv, output period, tMin);
endinterface

// file: hdl/pplf_vco.sv
// Feedback-controlled oscillator: piecewise-linear period from feedback.
// Assumes monotonic key points; recomputes the period every 33 cycles.
`timescale 1ns/1ps
`include "pplf_defines.svh"
module pplf_vco (
    input logic     ref_clk,
    input logic     rst_n,
    pplf_vco_if.vco vi
);
    pplf_pkg::pplf_vst_t q, d;
    logic [4:0][15:0]    vp, tp;
    logic [16:0]         r;
    logic [31:0]         qo;
    logic [1:0]          s;

    // Scales a nominal value by a factor with six fraction bits.
    function automatic logic [15:0] scl(input logic [15:0] a, input logic [7:0] k);
        logic [23:0] p;
        p = (a * k) >> `PPLF_KSH;
        return p[15:0];
    endfunction

    // ==========================================
    // Key points and segment choice.
    always_comb begin
        vp = {scl(vi.vNom, vi.kv[2]), scl(vi.vNom, vi.kv[1]), vi.vNom,
              scl(vi.vNom, vi.kv[0]), 16'h0000};
        tp = {scl(vi.tNom, vi.kf[3]), scl(vi.tNom, vi.kf[2]), vi.tNom,
              scl(vi.tNom, vi.kf[1]), scl(vi.tNom, vi.kf[0])};
        s = 2'h0;
        for (int i = 1; i < 4; i++) begin
            if (vi.fb >= vp[i]) begin
                s = 2'(i);
            end
        end
    end

    // Shift-subtract divider yields (Tb-Ta)*(fb-Va)/(Vb-Va).
    always_comb begin
        d = q;
        r = {q.rem[15:0], q.quo[31]};
        qo = {q.quo[30:0], 1'b0};
        d.tMin = tp[0];
        if (q.cnt == 6'h00) begin
            d.rem = '0;
            d.den = vp[s+1] - vp[s];
            d.base = (vi.fb >= vp[4]) ? tp[4] : tp[s];
            d.quo = (vi.fb >= vp[4]) ? 32'h0000_0000
                  : (tp[s+1] - tp[s]) * (vi.fb - vp[s]);
            d.cnt = 6'h01;
        end else begin
            if (r >= {1'b0, q.den}) begin
                r = r - {1'b0, q.den};
                qo[0] = 1'b1;
            end
            d.rem = r;
            d.quo = qo;
            d.cnt = q.cnt + 6'h01;
            if (q.cnt == 6'h20) begin
                d.period = (q.den == 16'h0000) ? q.base : q.base + qo[15:0];
                d.cnt = 6'h00;
            end
        end
        if (!rst_n) begin
            d = '0;
        end
    end

    // State register.
    always_ff @(posedge ref_clk) begin
        q <= d;
    end

    assign vi.period = q.period;
    assign vi.tMin = q.tMin;

    // Divider invariant keeps the interpolation exact.
    property p_remBound;
        @(posedge ref_clk) disable iff (!rst_n)
        (q.cnt > 6'h01 && q.den != 16'h0000) |-> q.rem < {1'b0, q.den};
    endproperty
    a_remBound: assert property (p_remBound) else $error("divider remainder too big");
endmodule

// file: hdl/pplf_top.sv
// Control core of a combined PFC and LLC controller with AXI4-Lite registers.
// Assumes sense values and comparator flags synchronous to ref_clk.
`timescale 1ns/1ps
`include "pplf_defines.svh"
module pplf_top #(
    parameter int unsigned AW       = 8,
    parameter int unsigned TICK_CYC = `PPLF_TICK_CYC
) (
    input  logic          ref_clk,
    input  logic          rst_n,
    input  logic          awvalid,
    output logic          awready,
    input  logic [AW-1:0] awaddr,
    input  logic          wvalid,
    output logic          wready,
    input  logic [31:0]   wdata,
    input  logic [3:0]    wstrb,
    output logic          bvalid,
    input  logic          bready,
    output logic [1:0]    bresp,
    input  logic          arvalid,
    output logic          arready,
    input  logic [AW-1:0] araddr,
    output logic          rvalid,
    input  logic          rready,
    output logic [31:0]   rdata,
    output logic [1:0]    rresp,
    input  logic [15:0]   busSense,
    input  logic [15:0]   busAvg,
    input  logic [15:0]   vacRms,
    input  logic [15:0]   hbFeedback,
    input  logic          ocpCmp,
    input  logic          fastOvCmp,
    input  logic          valleyDet,
    output logic          pfcGate,
    output logic          pfcEnable,
    output logic          llcEnable,
    output logic          llcSoftstart,
    output logic [15:0]   llcPeriod
);
    pplf_pkg::pplf_st_t q, d;
    pplf_vco_if         vi ();
    logic [15:0]        olThr, uvThr, ovThr, refBus, biThr, boThr;
    logic [15:0]        onTime, minOn, maxPer, ccmLim, stepMin;
    logic [7:0]         ovFilt, uvBlk, boBlk, arBrk;
    logic               openLoop, tmo, vly, ccmOk, ccmOver, ovfHit, en;
    logic [3:0]         arIdx;
    logic               arBad;
    pplf_vco u_vco (
        .ref_clk (ref_clk),
        .rst_n   (rst_n),
        .vi      (vi)
    );
    // ==========================================
    // Configuration fields.
    assign en     = q.cfg[`PPLF_R_CTRL][0];
    assign olThr  = q.cfg[`PPLF_R_OLUV][`PPLF_LO];
    assign uvThr  = q.cfg[`PPLF_R_OLUV][`PPLF_HI];
    assign ovThr  = q.cfg[`PPLF_R_OVREF][`PPLF_LO];
    assign refBus = q.cfg[`PPLF_R_OVREF][`PPLF_HI];
    assign biThr  = q.cfg[`PPLF_R_ACIN][`PPLF_LO];
    assign boThr  = q.cfg[`PPLF_R_ACIN][`PPLF_HI];
    assign ovFilt = q.cfg[`PPLF_R_BLANK][`PPLF_B0];
    assign uvBlk  = q.cfg[`PPLF_R_BLANK][`PPLF_B1];
    assign boBlk  = q.cfg[`PPLF_R_BLANK][`PPLF_B2];
    assign arBrk  = q.cfg[`PPLF_R_BLANK][`PPLF_B3];
    assign onTime = q.cfg[`PPLF_R_PFCT][`PPLF_LO];
    assign minOn  = q.cfg[`PPLF_R_PFCT][`PPLF_HI];
    assign maxPer = q.cfg[`PPLF_R_PERD][`PPLF_LO];
    assign ccmLim = q.cfg[`PPLF_R_PERD][`PPLF_HI];
    assign stepMin = q.cfg[`PPLF_R_SOFT][`PPLF_HI];
    // Feedback oscillator settings.
    assign vi.fb   = hbFeedback;
    assign vi.tNom = q.cfg[`PPLF_R_NOM][`PPLF_LO];
    assign vi.vNom = q.cfg[`PPLF_R_NOM][`PPLF_HI];
    assign vi.kf   = q.cfg[`PPLF_R_KFRQ];
    assign vi.kv   = q.cfg[`PPLF_R_KVLT][23:0];
    // Protection conditions seen this cycle.
    assign openLoop = busSense < olThr;
    assign tmo      = q.perCnt >= maxPer - 16'h0001;
    assign vly      = valleyDet && !q.pfcOn;
    assign ccmOk    = onTime > minOn + 16'(`PPLF_MARGIN_CYC);
    assign ccmOver  = q.ccmCnt > ccmLim;
    assign ovfHit   = fastOvCmp && q.ovfCnt >= ovFilt;
    assign arIdx    = araddr[5:2];
    assign arBad    = araddr[AW-1:6] != '0 || arIdx > `PPLF_R_LLCP;
    // ==========================================
    // Next state of the whole block.
    always_comb begin
        d = q;
        // Register bus write side: address and data in either order.
        if (awvalid && q.awRdy) begin
            d.awGot = 1'b1;
            d.awIdx = awaddr[5:2];
            d.awBad = awaddr[AW-1:6] != '0 || awaddr[5:2] > `PPLF_R_LLCP;
        end
        if (wvalid && q.wRdy) begin
            d.wGot = 1'b1;
            d.wData = wdata;
            d.wStrb = wstrb;
        end
        if (q.bValid && bready) begin
            d.bValid = 1'b0;
        end
        if (q.awGot && q.wGot && !q.bValid) begin
            d.awGot = 1'b0;
            d.wGot = 1'b0;
            d.bValid = 1'b1;
            d.bResp = q.awBad ? `PPLF_SLVERR : `PPLF_OKAY;
            if (!q.awBad && q.awIdx < 4'(`PPLF_NCFG)) begin
                for (int b = 0; b < 4; b++) begin
                    if (q.wStrb[b]) begin
                        d.cfg[q.awIdx][b*8 +: 8] = q.wData[b*8 +: 8];
                    end
                end
            end
            if (!q.awBad && q.awIdx == `PPLF_R_STAT) begin
                d.stat = q.stat & ~(q.wData[8:0] & {q.wStrb[1], {8{q.wStrb[0]}}});
            end
        end
        d.awRdy = !d.awGot && !d.bValid;
        d.wRdy = !d.wGot && !d.bValid;
        // Register bus read side.
        if (q.rValid && rready) begin
            d.rValid = 1'b0;
        end
        if (arvalid && q.arRdy) begin
            d.rValid = 1'b1;
            d.rResp = arBad ? `PPLF_SLVERR : `PPLF_OKAY;
            d.rData = 32'h0000_0000;
            if (!arBad && arIdx < 4'(`PPLF_NCFG)) begin
                d.rData = q.cfg[arIdx];
            end else if (!arBad && arIdx == `PPLF_R_STAT) begin
                d.rData = {23'h00_0000, q.stat};
            end else if (!arBad && arIdx == `PPLF_R_STATE) begin
                d.rData = {q.ccmCnt, 8'h00, q.boStop, q.uvStop, q.ovStop,
                           q.pfcEn, q.llcEn, q.llcSoft, q.sys};
            end else if (!arBad && arIdx == `PPLF_R_LLCP) begin
                d.rData = {16'h0000, q.llcPer};
            end
        end
        d.arRdy = !d.rValid;
        // Time base for softstart steps and blanking times.
        d.tickP = q.tick == 16'(TICK_CYC - 1);
        d.tick = d.tickP ? 16'h0000 : q.tick + 16'h0001;
        // Sticky event flags; set after the software clear so set wins.
        if (openLoop) begin
            d.stat[`PPLF_ST_OL] = 1'b1;
        end
        if (q.pfcOn && ocpCmp) begin
            d.stat[`PPLF_ST_OCP] = 1'b1;
        end
        // Fast overvoltage filter: comparator must stay high.
        d.ovfCnt = !fastOvCmp ? 8'h00 : (q.ovfCnt == 8'hFF) ? q.ovfCnt : q.ovfCnt + 8'h01;
        // Blanking counters advance once per tick while the fault lasts.
        if (busAvg >= uvThr) begin
            d.uvCnt = 8'h00;
        end else if (q.tickP && q.uvCnt != 8'hFF) begin
            d.uvCnt = q.uvCnt + 8'h01;
        end
        if (vacRms >= boThr) begin
            d.boCnt = 8'h00;
        end else if (q.tickP && q.boCnt != 8'hFF) begin
            d.boCnt = q.boCnt + 8'h01;
        end
        // PFC-only stop causes while the system runs.
        if (q.sys == pplf_pkg::S_RUN) begin
            if (busAvg > ovThr) begin
                d.ovStop = 1'b1;
                d.stat[`PPLF_ST_OV1] = 1'b1;
            end else if (ovfHit) begin
                d.ovStop = 1'b1;
                d.stat[`PPLF_ST_OV2] = 1'b1;
            end else if (busAvg <= refBus) begin
                d.ovStop = 1'b0;
            end
            if (busAvg < uvThr && q.uvCnt >= uvBlk) begin
                d.uvStop = 1'b1;
                d.stat[`PPLF_ST_UV] = 1'b1;
            end
            if (vacRms < boThr && q.boCnt >= boBlk) begin
                d.boStop = 1'b1;
                d.stat[`PPLF_ST_BO] = 1'b1;
            end else if (vacRms > biThr) begin
                d.boStop = 1'b0;
            end
        end
        // System sequence; a restart cause overrides the PFC-only stops.
        unique case (q.sys)
            pplf_pkg::S_IDLE: begin
                if (vacRms > biThr) begin
                    d.sys = pplf_pkg::S_START;
                    d.stat[`PPLF_ST_BI] = 1'b1;
                end
            end
            pplf_pkg::S_START: begin
                if (!openLoop && busAvg >= uvThr && busAvg <= ovThr) begin
                    d.sys = pplf_pkg::S_RUN;
                    d.llcSoft = 1'b1;
                    d.ssPer = vi.tMin;
                    d.ssStep = q.cfg[`PPLF_R_SOFT][`PPLF_LO];
                    d.ccmCnt = 16'h0000;
                    d.ovStop = 1'b0;
                    d.uvStop = 1'b0;
                    d.boStop = 1'b0;
                end
            end
            pplf_pkg::S_RUN: begin
                if (openLoop || ccmOver) begin
                    d.sys = pplf_pkg::S_RSTRT;
                    d.brkCnt = 8'h00;
                    d.stat[`PPLF_ST_AR] = 1'b1;
                    if (ccmOver) begin
                        d.stat[`PPLF_ST_CCM] = 1'b1;
                    end
                end
            end
            pplf_pkg::S_RSTRT: begin
                if (q.tickP) begin
                    d.brkCnt = q.brkCnt + 8'h01;
                end
                if (q.brkCnt >= arBrk) begin
                    d.sys = pplf_pkg::S_START;
                end
            end
        endcase
        if (!en) begin
            d.sys = pplf_pkg::S_IDLE;
        end
        d.llcEn = d.sys == pplf_pkg::S_RUN;
        d.pfcEn = d.llcEn && !(d.ovStop || d.uvStop || d.boStop);
        // PFC switching cycle: on-time, off-time, then valley or timeout.
        if (!d.pfcEn) begin
            d.pfcOn = 1'b0;
            d.perCnt = 16'h0000;
        end else if (vly || tmo) begin
            d.pfcOn = 1'b1;
            d.perCnt = 16'h0000;
            if (ccmOk) begin
                if (tmo && !vly) begin
                    d.ccmCnt = (q.ccmCnt == 16'hFFFF) ? q.ccmCnt : q.ccmCnt + 16'h0001;
                end else if (q.ccmCnt != 16'h0000) begin
                    d.ccmCnt = q.ccmCnt - 16'h0001;
                end
            end
        end else begin
            d.perCnt = q.perCnt + 16'h0001;
            if (q.pfcOn && (ocpCmp || q.perCnt + 16'h0001 >= onTime)) begin
                d.pfcOn = 1'b0;
            end
        end
        // LLC softstart steps and hand-over to the feedback oscillator.
        if (d.llcEn && q.llcSoft) begin
            if (vi.period <= q.ssPer) begin
                d.llcSoft = 1'b0;
            end else if (q.tickP) begin
                d.ssPer = q.ssPer + q.ssStep;
                d.ssStep = (q.ssStep - (q.ssStep >> 3) > stepMin)
                         ? q.ssStep - (q.ssStep >> 3) : stepMin;
            end
        end
        d.llcPer = !d.llcEn ? 16'h0000 : d.llcSoft ? d.ssPer : vi.period;
        // Synchronous reset to constants.
        if (!rst_n) begin
            d = '0;
            d.sys = pplf_pkg::S_IDLE;
            d.cfg[`PPLF_R_CTRL]  = `PPLF_RST_CTRL;
            d.cfg[`PPLF_R_OLUV]  = `PPLF_RST_OLUV;
            d.cfg[`PPLF_R_OVREF] = `PPLF_RST_OVREF;
            d.cfg[`PPLF_R_ACIN]  = `PPLF_RST_ACIN;
            d.cfg[`PPLF_R_BLANK] = `PPLF_RST_BLANK;
            d.cfg[`PPLF_R_PFCT]  = `PPLF_RST_PFCT;
            d.cfg[`PPLF_R_PERD]  = `PPLF_RST_PERD;
            d.cfg[`PPLF_R_SOFT]  = `PPLF_RST_SOFT;
            d.cfg[`PPLF_R_NOM]   = `PPLF_RST_NOM;
            d.cfg[`PPLF_R_KFRQ]  = `PPLF_RST_KFRQ;
            d.cfg[`PPLF_R_KVLT]  = `PPLF_RST_KVLT;
        end
    end
    // State register.
    always_ff @(posedge ref_clk) begin
        q <= d;
    end
    // ==========================================
    // Outputs, all taken from the state register.
    assign awready      = q.awRdy;
    assign wready       = q.wRdy;
    assign bvalid       = q.bValid;
    assign bresp        = q.bResp;
    assign arready      = q.arRdy;
    assign rvalid       = q.rValid;
    assign rdata        = q.rData;
    assign rresp        = q.rResp;
    assign pfcGate      = q.pfcOn;
    assign pfcEnable    = q.pfcEn;
    assign llcEnable    = q.llcEn;
    assign llcSoftstart = q.llcSoft;
    assign llcPeriod    = q.llcPer;
    // ==========================================
    // Checks.
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    property p_olFlag;
        openLoop |=> q.stat[`PPLF_ST_OL];
    endproperty
    a_olFlag: assert property (p_olFlag) else $error("open loop not flagged");
    property p_olStart;
        (q.sys == pplf_pkg::S_START && openLoop) |=> !q.llcEn && !q.pfcOn;
    endproperty
    a_olStart: assert property (p_olStart) else $error("started with open loop");
    property p_olRun;
        (q.sys == pplf_pkg::S_RUN && openLoop && en) |=> q.sys == pplf_pkg::S_RSTRT;
    endproperty
    a_olRun: assert property (p_olRun) else $error("open loop did not restart");
    property p_ocp;
        (q.pfcOn && ocpCmp && !tmo) |=> !q.pfcOn;
    endproperty
    a_ocp: assert property (p_ocp) else $error("overcurrent did not end on-time");
    property p_wait;
        (q.pfcEn && !q.pfcOn && !valleyDet && !tmo) |=> !q.pfcOn;
    endproperty
    a_wait: assert property (p_wait) else $error("cycle began without trigger");
    property p_ov1;
        (q.sys == pplf_pkg::S_RUN && en && busAvg > ovThr && !openLoop && !ccmOver)
            |=> q.ovStop && !q.pfcOn && q.llcEn;
    endproperty
    a_ov1: assert property (p_ov1) else $error("averaged overvoltage ignored");
    property p_ov2;
        (q.sys == pplf_pkg::S_RUN && en && ovfHit) |=> q.ovStop;
    endproperty
    a_ov2: assert property (p_ov2) else $error("fast overvoltage ignored");
    property p_ccmUp;
        (q.pfcEn && d.pfcEn && ccmOk && tmo && !vly && q.ccmCnt < 16'h00FF)
            |=> q.ccmCnt == $past(q.ccmCnt) + 16'h0001;
    endproperty
    a_ccmUp: assert property (p_ccmUp) else $error("conduction count missed");
    property p_ccmTrip;
        (q.sys == pplf_pkg::S_RUN && en && ccmOver) |=> q.sys == pplf_pkg::S_RSTRT ##1
            !q.llcEn [*2];
    endproperty
    a_ccmTrip: assert property (p_ccmTrip) else $error("conduction limit ignored");
endmodule

// file: bench/pplf_plant.sv
// Model of the power stage: valley detector and overcurrent comparator.
// Assumes the controller gate on the same clock; the bench requests overcurrent.
`timescale 1ns/1ps
module pplf_plant (
    input  wire logic ref_clk,
    input  wire logic pfcGate,
    input  wire logic ocpReq,
    output logic      ocpCmp = 1'b0,
    output logic      valleyDet = 1'b0
);
    // ==========================================
    // A valley rings six cycles after turn-off; overcurrent only with the gate on.
    int offCnt = 0;
    always @(posedge ref_clk) begin
        offCnt <= pfcGate ? 0 : offCnt + 1;
        valleyDet <= !pfcGate && offCnt == 5;
        ocpCmp <= pfcGate && ocpReq;
    end
endmodule

// file: bench/tb.sv
// Self-checking bench of the controller core with a stage model.
// Assumes the register map and reset values of the controller defines.
`timescale 1ns/1ps
`include "pplf_defines.svh"
module tb;
    logic ref_clk = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 1, arvalid = 0, rready = 1;
    logic ocpReq = 0, fastOvCmp = 0, awready, wready, bvalid, arready, rvalid, ocpCmp;
    logic valleyDet, pfcGate, pfcEnable, llcEnable, llcSoftstart;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0, rdata, rd;
    logic [3:0] wstrb = 4'hF;
    logic [15:0] busSense = 16'h0040, busAvg = 16'h0C00, vacRms = 0, hbFeedback = 16'h0190;
    logic [15:0] llcPeriod;
    logic [1:0] bresp, rresp, rs;
    int n_errors = 0, checks = 0, seed = 32'h0cc0ee71, i, ex;
    // Light-load segment end points of the period curve, from the reset settings.
    int tMn = ((`PPLF_RST_NOM & 32'hFFFF) * (`PPLF_RST_KFRQ & 32'hFF)) >> `PPLF_KSH;
    int tLl = ((`PPLF_RST_NOM & 32'hFFFF) * ((`PPLF_RST_KFRQ >> 8) & 32'hFF)) >> `PPLF_KSH;
    int vLl = ((`PPLF_RST_NOM >> 16) * (`PPLF_RST_KVLT & 32'hFF)) >> `PPLF_KSH;
    logic fbHold = 0;
    logic [31:0] rv [3] = '{`PPLF_RST_CTRL, `PPLF_RST_OLUV, `PPLF_RST_OVREF};
    pplf_top #(.TICK_CYC(16)) uut (.*);
    pplf_plant plant (.*);
    // ==========================================
    // Clock, random feedback and watchdog.
    always #12.5 ref_clk = ~ref_clk;
    always @(posedge ref_clk) if (!fbHold) hbFeedback <= 16'h0190 + 16'($random(seed) & 32'hFF);
    initial begin
        #500000;
        n_errors++;
        test_done();
    end
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("MISMATCH %s exp %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(posedge ref_clk);
            if (awready) awvalid <= 0;
            if (wready) wvalid <= 0;
        end while (!bvalid);
        rs = bresp;
    endtask
    task automatic rdr(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1;
        do begin
            @(posedge ref_clk);
            if (arready) arvalid <= 0;
        end while (!rvalid);
        rd = rdata;
        rs = rresp;
    endtask
    task automatic test_done;
        $display("checks %0d n_errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // ==========================================
    // Main sequence.
    initial begin
        repeat (8) @(posedge ref_clk);
        rst_n <= 1;
        @(posedge ref_clk);
        for (i = 0; i < 3; i++) begin
            rdr(8'(4 * i));
            chk("reset value", rd, rv[i]);
        end
        rdr(8'h40);
        chk("unmapped", 32'(rs), 32'(`PPLF_SLVERR));
        $display("test registers done");
        vacRms <= 16'h0700;
        repeat (300) @(posedge ref_clk);
        chk("llc held", 32'(llcEnable), 0);
        rdr(8'h2C);
        chk("open loop flag", 32'(rd[0]), 1);
        busSense <= 16'h0400;
        for (i = 0; i < 3000 && llcEnable !== 1; i++) @(posedge ref_clk);
        chk("brown-in run", 32'({llcEnable, llcSoftstart}), 3);
        wr(8'h2C, 32'h0000_01FF);
        chk("write resp", 32'(rs), 32'(`PPLF_OKAY));
        rdr(8'h2C);
        chk("flag cleared", 32'(rd[0]), 0);
        // Hold the feedback long enough for two full period computations.
        for (i = 0; i < 3; i++) begin
            fbHold <= 1;
            repeat (70) @(posedge ref_clk);
            ex = tMn + (tLl - tMn) * hbFeedback / vLl;
            chk("vco period", 32'(llcPeriod), ex);
            fbHold <= 0;
            @(posedge ref_clk);
        end
        $display("test start done");
        for (i = 0; i < 5000 && pfcGate !== 1; i++) @(posedge ref_clk);
        ocpReq <= 1;
        for (i = 0; i < 50 && ocpCmp !== 1; i++) @(posedge ref_clk);
        @(negedge ref_clk);
        chk("ocp cut", 32'(pfcGate), 0);
        ocpReq <= 0;
        for (i = 0; i < 50 && pfcGate !== 1; i++) @(posedge ref_clk);
        chk("valley restart", 32'(pfcGate), 1);
        busAvg <= 16'h0F00;
        repeat (20) @(posedge ref_clk);
        chk("ov1 stop", 32'({pfcEnable, llcEnable}), 1);
        busAvg <= 16'h0C00;
        repeat (20) @(posedge ref_clk);
        chk("ov1 resume", 32'(pfcEnable), 1);
        busSense <= 16'h0040;
        repeat (20) @(posedge ref_clk);
        chk("restart off", 32'({pfcEnable, llcEnable}), 0);
        rdr(8'h30);
        chk("restart state", 32'(rd[1:0]), 2);
        $display("test protection done");
        busSense <= 16'h0400;
        for (i = 0; i < 3000 && llcEnable !== 1; i++) @(posedge ref_clk);
        fastOvCmp <= 1;
        repeat (30) @(posedge ref_clk);
        chk("ov2 stop", 32'({pfcEnable, llcEnable}), 1);
        fastOvCmp <= 0;
        repeat (5) @(posedge ref_clk);
        chk("ov2 resume", 32'(pfcEnable), 1);
        // A short maximum period forces timeouts without valleys.
        wr(8'h18, 32'h0002_0010);
        repeat (100) @(posedge ref_clk);
        rdr(8'h2C);
        chk("ccm restart", 32'({llcEnable, rd[7]}), 1);
        $display("test conduction done");
        test_done();
    end
endmodule
